// ===== design/pesd_params.svh
// constants for the performance event select decoder
`ifndef PESD_PARAMS_SVH
`define PESD_PARAMS_SVH

// widths and slot counts
`define PESD_CNT_W        40
`define PESD_INC_W        4
`define PESD_DEC_SLOTS    4
`define PESD_SIMD_LANES   3
`define PESD_RET_SLOTS    4
`define PESD_HIT_W        8

// register byte offsets
`define PESD_OFS_CTRL     8'h00
`define PESD_OFS_EVTSEL   8'h04
`define PESD_OFS_CNT_LO   8'h08
`define PESD_OFS_CNT_HI   8'h0C
`define PESD_OFS_SAMPLE   8'h10
`define PESD_OFS_STATUS   8'h14

// reset values
`define PESD_RST_EVT      8'h00
`define PESD_RST_UMASK    8'h00
`define PESD_RST_CIDX     2'h0

// field positions
`define PESD_CTRL_EN_BIT  0
`define PESD_CTRL_CIDX_LO 1
`define PESD_EVT_LO       0
`define PESD_UMASK_LO     8
`define PESD_ST_SVALID    0
`define PESD_ST_INC_LO    4

// event numbers
`define PESD_EV_DISPATCH  8'hA1
`define PESD_EV_DECODE    8'hAA
`define PESD_EV_SP        8'hAB
`define PESD_EV_SIMD_EX   8'hB0
`define PESD_EV_SIMD_SAT  8'hB1
`define PESD_EV_SIMD_TYPE 8'hB3
`define PESD_EV_INST_RET  8'hC0
`define PESD_EV_X87_RET   8'hC1
`define PESD_EV_UOPS_RET  8'hC2
`define PESD_EV_MCLEAR    8'hC3

// unit masks
`define PESD_UM_00        8'h00
`define PESD_UM_01        8'h01
`define PESD_UM_02        8'h02
`define PESD_UM_04        8'h04
`define PESD_UM_07        8'h07
`define PESD_UM_08        8'h08
`define PESD_UM_0F        8'h0F
`define PESD_UM_10        8'h10
`define PESD_UM_20        8'h20
`define PESD_UM_FE        8'hFE

`endif

// ===== design/pesd_pkg.sv
// types for the performance event select decoder
`include "pesd_params.svh"
package pesd_pkg;
  typedef struct packed {
    logic                   enable;
    logic [1:0]             cidx;
    logic [7:0]             evt;
    logic [7:0]             umask;
    logic [`PESD_CNT_W-1:0] count;
    logic [31:0]            sample_addr;
    logic                   sample_valid;
    logic [`PESD_INC_W-1:0] last_inc;
    logic                   ack;
    logic [31:0]            dat;
  } pesd_state_t;
endpackage

// ===== design/pesd_top.sv
// event decode, counting and wishbone register slave of the performance monitor
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pesd_params.svh"

// How it works
// - event A1H umask 08H/10H/20H counts port 3/4/5 dispatch cycles, one each.
// - per-port dispatch events count only when counter_zero is selected.
// - AAH 01H counts every decoded instruction, executed or not.
// - AAH 08H counts complex decodes; at most one complex decode per cycle.
// - ABH 01H counts explicit stack pointer uses after implicit use.
// - ABH 02H counts decoder-performed stack pointer additions.
// - B0H 00H counts executed SIMD micro-ops except register-to-memory moves.
// - B1H 00H counts executed saturating SIMD micro-ops.
// - B3H counts SIMD micro-ops by class selected by unit mask bit.
// - C0H 00H adds one per instruction, at retirement of its last micro-op.
// - retired instruction counting never pauses for interrupts or traps.
// - C0H 01H/02H/04H count retired instructions with load, store, neither.
// - C1H 01H counts retired floating-point register exchanges.
// - C1H FEH counts retired x87 compute ops, minus trapping/assisted, loads, stores.
// - precise sample stores address of the instruction after the causing one.
// - C2H 01H counts retired load-fused micro-ops.
// - C2H 02H counts retired store address-data fused micro-ops.
// - C2H 04H counts retired compare-branch fused micro-ops.
// - C2H 07H counts retired fused micro-ops of all three kinds.
// - C2H 08H counts retired micro-ops that were not fused.
// - C2H 0FH counts every retired micro-op, long sequences included.
// - C3H 01H counts each write by the program into a code region.
module pesd_top
  import pesd_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [7:0]                    adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [31:0]                   dat_i,
  output logic      [31:0]                   dat_o,
  output logic                               ack_o,
  // pipeline levels below are all on clk_i, so no synchroniser stage
  // dispatch stage, one bit per port 3, 4, 5
  input  wire logic [2:0]                    port_dispatch_i,
  // decode stage, one bit per decoder slot
  input  wire logic [`PESD_DEC_SLOTS-1:0]    dec_valid_i,
  input  wire logic [`PESD_DEC_SLOTS-1:0]    dec_complex_i,
  input  wire logic [`PESD_DEC_SLOTS-1:0]    sp_sync_i,
  input  wire logic [`PESD_DEC_SLOTS-1:0]    sp_auto_add_i,
  // simd execution lanes
  input  wire logic [`PESD_SIMD_LANES-1:0]   simd_valid_i,
  input  wire logic [`PESD_SIMD_LANES-1:0]   simd_mov_store_i,
  input  wire logic [`PESD_SIMD_LANES-1:0]   simd_sat_i,
  input  wire logic [`PESD_SIMD_LANES*6-1:0] simd_class_i,
  // retirement slots
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_valid_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_last_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_load_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_store_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_fp_xchg_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_x87_comp_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_x87_assist_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_x87_ldst_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_fuse_load_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_fuse_store_i,
  input  wire logic [`PESD_RET_SLOTS-1:0]    ret_fuse_cmpbr_i,
  input  wire logic [31:0]                   ret_next_ip_i,
  // memory stage
  input  wire logic                          smc_write_i,
  // counter view
  output logic      [`PESD_CNT_W-1:0]        count_o,
  output logic      [`PESD_INC_W-1:0]        inc_o
);

  // all state in one struct: bus answer, selection, counter, sample
  // next value built by one always_comb, registered by one always_ff
  pesd_state_t state_reg;
  pesd_state_t state_next;

  // per-slot qualifying conditions
  logic [`PESD_SIMD_LANES-1:0] simd_ok;
  logic [`PESD_SIMD_LANES-1:0] simd_cls_hit;
  logic [`PESD_RET_SLOTS-1:0]  ret_instr;
  logic [`PESD_RET_SLOTS-1:0]  ret_none_mem;
  logic [`PESD_RET_SLOTS-1:0]  ret_x87_ok;
  logic [`PESD_RET_SLOTS-1:0]  ret_any_fused;
  logic [`PESD_RET_SLOTS-1:0]  ret_unfused;

  genvar g;

  // simd lanes: register-to-memory moves never count as executed
  // class bits outside the unit mask are masked, so a lane counts once at most
  generate
    for (g = 0; g < `PESD_SIMD_LANES; g++)
    begin : g_simd
      assign simd_ok[g]      = simd_valid_i[g] & ~simd_mov_store_i[g];
      assign simd_cls_hit[g] = simd_valid_i[g] &
                               (|(simd_class_i[g*6 +: 6] & state_reg.umask[5:0]));
    end
  endgenerate

  // retirement slots; no interrupt or trap input gates these terms
  // a slot with ret_last_i low is an inner micro-op of a longer instruction
  generate
    for (g = 0; g < `PESD_RET_SLOTS; g++)
    begin : g_ret
      assign ret_instr[g]     = ret_valid_i[g] & ret_last_i[g];
      assign ret_none_mem[g]  = ret_instr[g] & ~ret_load_i[g] & ~ret_store_i[g];
      assign ret_x87_ok[g]    = ret_valid_i[g] & ret_x87_comp_i[g] &
                                ~ret_x87_assist_i[g] & ~ret_x87_ldst_i[g];
      assign ret_any_fused[g] = ret_valid_i[g] &
                                (ret_fuse_load_i[g] | ret_fuse_store_i[g] |
                                 ret_fuse_cmpbr_i[g]);
      assign ret_unfused[g]   = ret_valid_i[g] & ~(ret_fuse_load_i[g] |
                                ret_fuse_store_i[g] | ret_fuse_cmpbr_i[g]);
    end
  endgenerate

  // widen a slot vector onto the common hit vector
  // upper hit bits stay zero for the narrower sources
  function automatic logic [`PESD_HIT_W-1:0] pad_hits(input logic [`PESD_RET_SLOTS-1:0] v);
    pad_hits = {{(`PESD_HIT_W-`PESD_RET_SLOTS){1'b0}}, v};
  endfunction

  function automatic logic [`PESD_HIT_W-1:0] pad_simd(input logic [`PESD_SIMD_LANES-1:0] v);
    pad_simd = {{(`PESD_HIT_W-`PESD_SIMD_LANES){1'b0}}, v};
  endfunction

  // event and unit mask select one hit vector; unknown pairs stay zero
  // one popcount after the mux keeps a single adder for every event
  // eight hit bits cover the widest source, with room to spare
  logic [`PESD_HIT_W-1:0] hits;
  logic                   precise_evt;

  always_comb
  begin
    hits        = '0;
    precise_evt = 1'b0;
    case (state_reg.evt)
      `PESD_EV_DISPATCH:
      begin
        // only counter_zero may take per-port dispatch; one per port per cycle
        // a port dispatches at most one micro-op a cycle, so one bit suffices
        if (state_reg.cidx == 2'h0)
        begin
          case (state_reg.umask)
            `PESD_UM_08: hits[0] = port_dispatch_i[0];
            `PESD_UM_10: hits[0] = port_dispatch_i[1];
            `PESD_UM_20: hits[0] = port_dispatch_i[2];
            default:     hits    = '0;
          endcase
        end
      end
      `PESD_EV_DECODE:
      begin
        case (state_reg.umask)
          `PESD_UM_01: hits = pad_hits(dec_valid_i);
          // a single complex decoder, so never more than one per cycle
          `PESD_UM_08: hits[0] = |(dec_valid_i & dec_complex_i);
          default:     hits = '0;
        endcase
      end
      `PESD_EV_SP:
      begin
        case (state_reg.umask)
          `PESD_UM_01: hits = pad_hits(sp_sync_i);
          `PESD_UM_02: hits = pad_hits(sp_auto_add_i);
          default:     hits = '0;
        endcase
      end
      `PESD_EV_SIMD_EX:
      begin
        if (state_reg.umask == `PESD_UM_00)
          hits = pad_simd(simd_ok);
      end
      `PESD_EV_SIMD_SAT:
      begin
        if (state_reg.umask == `PESD_UM_00)
          hits = pad_simd(simd_valid_i & simd_sat_i);
      end
      `PESD_EV_SIMD_TYPE:
      begin
        // exactly one class bit selects; combinations are not defined
        case (state_reg.umask)
          `PESD_UM_01, `PESD_UM_02, `PESD_UM_04,
          `PESD_UM_08, `PESD_UM_10, `PESD_UM_20: hits = pad_simd(simd_cls_hit);
          default: hits = '0;
        endcase
      end
      `PESD_EV_INST_RET:
      begin
        case (state_reg.umask)
          `PESD_UM_00: hits = pad_hits(ret_instr);
          `PESD_UM_01: hits = pad_hits(ret_instr & ret_load_i);
          `PESD_UM_02: hits = pad_hits(ret_instr & ret_store_i);
          `PESD_UM_04: hits = pad_hits(ret_none_mem);
          default:     hits = '0;
        endcase
      end
      `PESD_EV_X87_RET:
      begin
        case (state_reg.umask)
          `PESD_UM_01: hits = pad_hits(ret_instr & ret_fp_xchg_i);
          `PESD_UM_FE:
          begin
            hits        = pad_hits(ret_x87_ok);
            precise_evt = 1'b1;
          end
          default:     hits = '0;
        endcase
      end
      `PESD_EV_UOPS_RET:
      begin
        case (state_reg.umask)
          `PESD_UM_01: hits = pad_hits(ret_valid_i & ret_fuse_load_i);
          `PESD_UM_02: hits = pad_hits(ret_valid_i & ret_fuse_store_i);
          `PESD_UM_04: hits = pad_hits(ret_valid_i & ret_fuse_cmpbr_i);
          `PESD_UM_07: hits = pad_hits(ret_any_fused);
          `PESD_UM_08: hits = pad_hits(ret_unfused);
          `PESD_UM_0F: hits = pad_hits(ret_valid_i);
          default:     hits = '0;
        endcase
      end
      `PESD_EV_MCLEAR:
      begin
        if (state_reg.umask == `PESD_UM_01)
          hits[0] = smc_write_i;
      end
      default: hits = '0;
    endcase
  end

  // population count of this cycle's hits
  // up to four hits a cycle, from at most four slots, so four bits hold the increment with room to spare
  logic [`PESD_INC_W-1:0] inc;

  always_comb
  begin
    inc = '0;
    for (int i = 0; i < `PESD_HIT_W; i++)
      inc = inc + {{(`PESD_INC_W-1){1'b0}}, hits[i]};
  end

  // register read mux
  // decoded from the live address and registered into dat, so dat_o
  // is ready in the ack cycle with no extra wait state
  logic [31:0] rd_data;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      `PESD_OFS_CTRL:
      begin
        rd_data[`PESD_CTRL_EN_BIT]                    = state_reg.enable;
        rd_data[`PESD_CTRL_CIDX_LO +: 2]              = state_reg.cidx;
      end
      `PESD_OFS_EVTSEL:
      begin
        rd_data[`PESD_EVT_LO +: 8]                    = state_reg.evt;
        rd_data[`PESD_UMASK_LO +: 8]                  = state_reg.umask;
      end
      `PESD_OFS_CNT_LO: rd_data = state_reg.count[31:0];
      `PESD_OFS_CNT_HI: rd_data[`PESD_CNT_W-33:0] = state_reg.count[`PESD_CNT_W-1:32];
      `PESD_OFS_SAMPLE: rd_data = state_reg.sample_addr;
      `PESD_OFS_STATUS:
      begin
        rd_data[`PESD_ST_SVALID]                      = state_reg.sample_valid;
        rd_data[`PESD_ST_INC_LO +: `PESD_INC_W]       = state_reg.last_inc;
      end
      default: rd_data = 32'h0000_0000; // unmapped reads as zero
    endcase
  end

  // byte-lane merge for writes
  // byte lanes with sel_i low keep their old contents
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
  endfunction

  // write qualifier and merged write words per register
  logic        wr_en;
  logic [31:0] ctrl_w;
  logic [31:0] evt_w;
  logic [31:0] hi_w;

  // one request per ack: the request cycle writes, ack follows one edge later
  // the ack cycle still shows cyc and stb; gating on ack stops a second write
  assign wr_en  = cyc_i & stb_i & we_i & ~state_reg.ack;
  assign ctrl_w = merge({29'h0, state_reg.cidx, state_reg.enable}, dat_i, sel_i);
  assign evt_w  = merge({16'h0, state_reg.umask, state_reg.evt}, dat_i, sel_i);
  assign hi_w   = merge({{(64-`PESD_CNT_W){1'b0}}, state_reg.count[`PESD_CNT_W-1:32]},
                        dat_i, sel_i);

  // next state
  // order: count, then capture, then bus writes, so a write has the last word, except a status clear, which a capture in the same cycle beats
  always_comb
  begin
    state_next          = state_reg;
    state_next.ack      = cyc_i & stb_i & ~state_reg.ack;
    state_next.dat      = rd_data;
    state_next.last_inc = state_reg.enable ? inc : '0;
    // counting; a software write to the counter in the same cycle wins
    if (state_reg.enable)
      state_next.count = state_reg.count + {{(`PESD_CNT_W-`PESD_INC_W){1'b0}}, inc};
    // precise capture keeps the address that follows the causing instruction
    // only the retired x87 compute event, C1H FEH, is precise in this block
    if (state_reg.enable && precise_evt && (inc != '0))
    begin
      state_next.sample_addr  = ret_next_ip_i;
      state_next.sample_valid = 1'b1;
    end
    if (wr_en)
    begin
      case (adr_i)
        `PESD_OFS_CTRL:
        begin
          state_next.enable = ctrl_w[`PESD_CTRL_EN_BIT];
          state_next.cidx   = ctrl_w[`PESD_CTRL_CIDX_LO +: 2];
        end
        `PESD_OFS_EVTSEL:
        begin
          state_next.evt    = evt_w[`PESD_EVT_LO +: 8];
          state_next.umask  = evt_w[`PESD_UMASK_LO +: 8];
        end
        // halves are written apart; stop counting first or a carry may be lost
        `PESD_OFS_CNT_LO:
          state_next.count[31:0] = merge(state_reg.count[31:0], dat_i, sel_i);
        `PESD_OFS_CNT_HI:
          state_next.count[`PESD_CNT_W-1:32] = hi_w[`PESD_CNT_W-33:0];
        `PESD_OFS_STATUS:
        begin
          // write one to clear; a capture in the same cycle wins
          // so a clear never drops a sample captured in that same cycle
          if (sel_i[0] && dat_i[`PESD_ST_SVALID] &&
              !(state_reg.enable && precise_evt && (inc != '0)))
            state_next.sample_valid = 1'b0;
        end
        default: state_next.sample_valid = state_next.sample_valid; // ignored
      endcase
    end
  end

  // single state register
  // synchronous reset; the zero selection is an undefined pair and adds nothing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg       <= '0;
      state_reg.evt   <= `PESD_RST_EVT;
      state_reg.umask <= `PESD_RST_UMASK;
      state_reg.cidx  <= `PESD_RST_CIDX;
    end
    else
      state_reg <= state_next;
  end

  // outputs straight from the state
  // every output is a flop, so no path from the pipeline inputs leaves the block
  assign ack_o   = state_reg.ack;
  assign dat_o   = state_reg.dat;
  assign count_o = state_reg.count;
  assign inc_o   = state_reg.last_inc;

endmodule
`default_nettype wire

// ===== bench/pesd_pipe_model.sv
// pipeline stages model driving per-cycle event indications
`timescale 1ns/1ps
`default_nettype none
module pesd_pipe_model (
  // clock
  input  wire logic         clk_i,
  // traffic runs while high
  input  wire logic         act_i,
  // packed indications, sliced by the bench
  output logic      [122:0] ev_o
);
  integer       seed = 32'haccf;
  logic [127:0] r;

  initial ev_o = '0;

  // fresh random traffic each cycle; qualifiers never outside their valid bits
  always @(posedge clk_i)
  begin
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    r[10:7] = r[6:3] & (4'h1 << r[125:124]);
    for (int k = 11; k < 19; k += 4)
      r[k+:4] = r[k+:4] & r[6:3];
    for (int k = 22; k < 28; k += 3)
      r[k+:3] = r[k+:3] & r[21:19];
    // one class per lane, so class counts stay exact
    for (int g = 0; g < 3; g++)
      r[28+g*6+:6] = r[19+g] ? 6'h01 << (r[100+g*3+:3] % 6) : 6'h00;
    for (int k = 50; k < 90; k += 4)
      r[k+:4] = r[k+:4] & r[49:46];
    ev_o <= act_i ? r[122:0] : 123'h0;
  end
endmodule
`default_nettype wire

// ===== bench/pesd_top_properties.sv
// port assertions for the event decoder
`timescale 1ns/1ps
`default_nettype none
module pesd_top_properties (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_o,
  // pipeline
  input  wire logic [2:0]  port_dispatch_i,
  input  wire logic [3:0]  dec_valid_i,
  input  wire logic [2:0]  simd_valid_i,
  input  wire logic [2:0]  simd_mov_store_i,
  input  wire logic [3:0]  ret_valid_i,
  input  wire logic [3:0]  ret_last_i,
  input  wire logic        smc_write_i,
  // counter
  input  wire logic [39:0] count_o,
  input  wire logic [3:0]  inc_o
);
  logic        en_reg;
  logic [1:0]  cidx_reg;
  logic [15:0] sel_reg;
  logic        wr;

  assign wr = cyc_i & stb_i & we_i;

  // shadow selection, taken on the same edge as the slave takes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_reg   <= 1'b0;
      cidx_reg <= 2'h0;
      sel_reg  <= 16'h0;
    end
    else if (wr && !ack_o && adr_i == 8'h00)
    begin
      en_reg   <= dat_i[0];
      cidx_reg <= dat_i[2:1];
    end
    else if (wr && !ack_o && adr_i == 8'h04)
      sel_reg <= {dat_i[7:0], dat_i[15:8]};
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_on(logic [15:0] x);
    en_reg && cidx_reg == 2'h0 && sel_reg == x;
  endsequence

  AST_PORT3: assert property (s_on(16'hA108) |=>
    inc_o == {3'h0, $past(port_dispatch_i[0])})
    else $error("port 3 dispatch count wrong");
  AST_PORT_OTHER: assert property (
    en_reg && cidx_reg != 2'h0 && sel_reg[15:8] == 8'hA1 |=> inc_o == 4'h0)
    else $error("dispatch counted off counter zero");
  AST_DECODED: assert property (s_on(16'hAA01) |=>
    inc_o == $countones($past(dec_valid_i)))
    else $error("decoded count wrong");
  AST_COMPLEX: assert property (s_on(16'hAA08) |=> inc_o <= 4'h1)
    else $error("more than one complex decode");
  AST_SIMD: assert property (s_on(16'hB000) |=>
    inc_o == $countones($past(simd_valid_i) & ~$past(simd_mov_store_i)))
    else $error("simd executed count wrong");
  AST_RETIRED: assert property (s_on(16'hC000) |=>
    inc_o == $countones($past(ret_valid_i) & $past(ret_last_i)))
    else $error("retired instruction count wrong");
  AST_UOPS: assert property (s_on(16'hC20F) |=> inc_o == $countones($past(ret_valid_i)))
    else $error("retired uop count wrong");
  AST_SMC: assert property (s_on(16'hC301) |=> inc_o == {3'h0, $past(smc_write_i)})
    else $error("code write count wrong");
  AST_ACCUM: assert property (en_reg && !wr |=> count_o == $past(count_o) + 40'(inc_o))
    else $error("counter did not add increment");
  AST_HOLD: assert property (!en_reg && !wr |=> inc_o == 4'h0 && $stable(count_o))
    else $error("disabled counter moved");
endmodule

bind pesd_top pesd_top_properties u_props (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .ack_o, .port_dispatch_i,
  .dec_valid_i, .simd_valid_i, .simd_mov_store_i, .ret_valid_i, .ret_last_i,
  .smc_write_i, .count_o, .inc_o
);
`default_nettype wire

// ===== bench/pesd_top_tb.sv
// self-checking bench for the event decoder
`timescale 1ns/1ps
`default_nettype none
`include "pesd_params.svh"
module pesd_top_tb;
  logic         clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, act, en, chk, got;
  logic [7:0]   adr_i;
  logic [3:0]   sel_i, inc_o;
  logic [31:0]  dat_i, dat_o, q, q2, exp_samp, ipm;
  logic [39:0]  count_o, exp_cnt;
  logic [122:0] ev;
  logic [1:0]   cidx;
  logic [15:0]  sel;
  int           errors, tests_run, hm;
  logic [15:0]  codes [31] = '{16'hA108, 16'hA110, 16'hA120, 16'hAA01, 16'hAA08,
    16'hAB01, 16'hAB02, 16'hB000, 16'hB100, 16'hB301, 16'hB302, 16'hB304, 16'hB308,
    16'hB310, 16'hB320, 16'hC000, 16'hC001, 16'hC002, 16'hC004, 16'hC101, 16'hC1FE,
    16'hC201, 16'hC202, 16'hC204, 16'hC207, 16'hC208, 16'hC20F, 16'hC301, 16'hC20F,
    16'hA120, 16'hAA01};

  pesd_pipe_model u_pipe (.clk_i(clk_i), .act_i(act), .ev_o(ev));

  pesd_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .port_dispatch_i(ev[2:0]), .dec_valid_i(ev[6:3]), .dec_complex_i(ev[10:7]),
    .sp_sync_i(ev[14:11]), .sp_auto_add_i(ev[18:15]), .simd_valid_i(ev[21:19]),
    .simd_mov_store_i(ev[24:22]), .simd_sat_i(ev[27:25]), .simd_class_i(ev[45:28]),
    .ret_valid_i(ev[49:46]), .ret_last_i(ev[53:50]), .ret_load_i(ev[57:54]),
    .ret_store_i(ev[61:58]), .ret_fp_xchg_i(ev[65:62]), .ret_x87_comp_i(ev[69:66]),
    .ret_x87_assist_i(ev[73:70]), .ret_x87_ldst_i(ev[77:74]), .ret_fuse_load_i(ev[81:78]),
    .ret_fuse_store_i(ev[85:82]), .ret_fuse_cmpbr_i(ev[89:86]),
    .ret_next_ip_i(ev[121:90]), .smc_write_i(ev[122]), .count_o(count_o), .inc_o(inc_o)
  );

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // reference count of one cycle's hits under the current selection
  function automatic int hits(input logic [122:0] e);
    logic [3:0] v, l, fu;
    v = e[49:46];
    l = e[53:50] & v;
    fu = e[81:78] | e[85:82] | e[89:86];
    if (!en)
      return 0;
    case (sel)
      16'hA108, 16'hA110, 16'hA120:
        return cidx == 2'h0 ? $countones(e[2:0] & sel[5:3]) : 0;
      16'hAA01: return $countones(e[6:3]);
      16'hAA08: return int'(|e[10:7]);
      16'hAB01: return $countones(e[14:11]);
      16'hAB02: return $countones(e[18:15]);
      16'hB000: return $countones(e[21:19] & ~e[24:22]);
      16'hB100: return $countones(e[27:25]);
      16'hB301, 16'hB302, 16'hB304, 16'hB308, 16'hB310, 16'hB320:
        return $countones(e[45:28] & {3{sel[5:0]}});
      16'hC000: return $countones(l);
      16'hC001: return $countones(l & e[57:54]);
      16'hC002: return $countones(l & e[61:58]);
      16'hC004: return $countones(l & ~e[57:54] & ~e[61:58]);
      16'hC101: return $countones(l & e[65:62]);
      16'hC1FE: return $countones(v & e[69:66] & ~e[73:70] & ~e[77:74]);
      16'hC201: return $countones(e[81:78]);
      16'hC202: return $countones(e[85:82]);
      16'hC204: return $countones(e[89:86]);
      16'hC207: return $countones(fu);
      16'hC208: return $countones(v & ~fu);
      16'hC20F: return $countones(v);
      16'hC301: return int'(e[122]);
      default: return 0;
    endcase
  endfunction

  task automatic check(input logic [39:0] seen, input logic [39:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, expv);
    end
  endtask

  // one classic cycle; only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  // select, clear, run random traffic, then read the counter back
  task automatic run(input logic e, input logic [1:0] c, input logic [15:0] s);
    wb(1'b1, `PESD_OFS_CTRL, 32'h0, q);
    wb(1'b1, `PESD_OFS_EVTSEL, {16'h0, s[7:0], s[15:8]}, q);
    wb(1'b1, `PESD_OFS_CNT_LO, 32'h0, q);
    wb(1'b1, `PESD_OFS_CNT_HI, 32'h0, q);
    wb(1'b1, `PESD_OFS_CTRL, {29'h0, c, e}, q);
    en = e;
    cidx = c;
    sel = s;
    exp_cnt = 40'h0;
    got = 1'b0;
    chk = 1'b1;
    act <= 1'b1;
    repeat (20) @(posedge clk_i);
    act <= 1'b0;
    repeat (2) @(posedge clk_i);
    #2 chk = 1'b0;
    wb(1'b0, `PESD_OFS_CNT_LO, 32'h0, q);
    wb(1'b0, `PESD_OFS_CNT_HI, 32'h0, q2);
    check({q2[7:0], q}, exp_cnt);
    if (got)
    begin
      wb(1'b0, `PESD_OFS_SAMPLE, 32'h0, q);
      check({8'h0, q}, {8'h0, exp_samp});
      wb(1'b0, `PESD_OFS_STATUS, 32'h0, q);
      check({39'h0, q[0]}, 40'h1);
      wb(1'b1, `PESD_OFS_STATUS, 32'h1, q);
      wb(1'b0, `PESD_OFS_STATUS, 32'h0, q);
      check({39'h0, q[0]}, 40'h0);
    end
    $display("test %h cidx %0d en %0d done", s, c, e);
  endtask

  // per-cycle compare of increment and running count
  always @(posedge clk_i)
  begin
    hm = hits(ev);
    ipm = ev[121:90];
    #1;
    if (chk)
    begin
      check({36'h0, inc_o}, 40'(hm));
      exp_cnt = exp_cnt + 40'(hm);
      check(count_o, exp_cnt);
      if (en && sel == 16'hC1FE && hm > 0)
      begin
        exp_samp = ipm;
        got = 1'b1;
      end
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial
  begin
    #300000;
    errors++;
    finish_test();
  end

  // main sequence
  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, act, chk, en, got} = 8'h80;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0;
    cidx = 2'h0;
    sel = 16'h0;
    exp_cnt = 40'h0;
    errors = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a += 4)
    begin
      wb(1'b0, 8'(a), 32'h0, q);
      check({8'h0, q}, 40'h0);
    end
    wb(1'b1, 8'h18, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h18, 32'h0, q);
    check({8'h0, q}, 40'h0);
    foreach (codes[i])
      run(1'b1, 2'h0, codes[i]);
    wb(1'b0, `PESD_OFS_EVTSEL, 32'h0, q);
    check({8'h0, q}, 40'h00_0000_01AA);
    run(1'b1, 2'h1, 16'hA108);
    run(1'b1, 2'h0, 16'hB303);
    run(1'b0, 2'h0, 16'hC20F);
    finish_test();
  end
endmodule
`default_nettype wire
